// file: rtl/segp_regs.svh
`ifndef SEGP_REGS_SVH
`define SEGP_REGS_SVH
// Segment register indices
`define SEGP_SEG_EXTRA     3'h0
`define SEGP_SEG_CODE      3'h1
`define SEGP_SEG_STACK     3'h2
`define SEGP_SEG_DATA      3'h3
`define SEGP_SEG_AUXF      3'h4
`define SEGP_SEG_AUXG      3'h5
`define SEGP_NUM_SEG       6
// Descriptor field positions (64-bit descriptor)
`define SEGP_D_LIMLO_HI    15
`define SEGP_D_BASELO_HI   39
`define SEGP_D_BASELO_LO   16
`define SEGP_D_TYPE_HI     43
`define SEGP_D_TYPE_LO     40
`define SEGP_D_SBIT        44
`define SEGP_D_DPL_HI      46
`define SEGP_D_DPL_LO      45
`define SEGP_D_LIMHI_HI    51
`define SEGP_D_LIMHI_LO    48
`define SEGP_D_G           55
`define SEGP_D_BASEHI_HI   63
`define SEGP_D_BASEHI_LO   56
// Type bit positions for code and data segments
`define SEGP_T_EXEC        3
`define SEGP_T_CONF_DOWN   2
`define SEGP_T_RD_WR       1
// Scaled limit fill and real-mode values
`define SEGP_SCALE_FILL    12'hFFF
`define SEGP_REAL_LIMIT    32'h0000FFFF
`define SEGP_REAL_TYPE     4'h2
// Reset values
`define SEGP_RST_TBL_LIMIT 16'h0000
`define SEGP_RST_PRIV      2'h0
`endif

// file: rtl/segp_pkg.sv
package segp_pkg;
  // System descriptor kinds; reserved codes fold onto SEGP_SYS_RSVD
  typedef enum logic [3:0] {
    SEGP_SYS_RSVD      = 4'h0,
    SEGP_SYS_TSA16_AV  = 4'h1,
    SEGP_SYS_LOCAL_TBL = 4'h2,
    SEGP_SYS_TSA16_BSY = 4'h3,
    SEGP_SYS_CALL16    = 4'h4,
    SEGP_SYS_TASKG     = 4'h5,
    SEGP_SYS_INT16     = 4'h6,
    SEGP_SYS_TRAP16    = 4'h7,
    SEGP_SYS_TSA32_AV  = 4'h9,
    SEGP_SYS_TSA32_BSY = 4'hB,
    SEGP_SYS_CALL32    = 4'hC,
    SEGP_SYS_INT32     = 4'hE,
    SEGP_SYS_TASKG32   = 4'hF
  } segp_sys_t;
  // Access width codes
  typedef enum logic [1:0] {
    SEGP_W_BYTE  = 2'h0,
    SEGP_W_WORD  = 2'h1,
    SEGP_W_DWORD = 2'h2
  } segp_width_t;
  // Hidden part of one segment register
  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [31:0] limit;
    logic [3:0]  typ;
    logic        sbit;
    logic [1:0]  segment_priv_level;
    logic        nul;
  } segp_cache_t;
endpackage : segp_pkg

// file: rtl/segp_checker.sv
// Operation
// - decode system types 1 to 7
// - decode types 9,11,12,14,15; others reserved
// - check types at load and at use
// - code register takes executable segments only
// - execute-only segments barred from data registers
// - stack register needs writable data segment
// - writes to executable segments fault
// - writes to read-only data segments fault
// - executable reads need readable bit
// - unscaled limit is raw byte limit
// - scaled limit in 4K units, low bits free
// - byte, word, doubleword end within limit
// - grow-down allows limit plus one upward
// - global table limit bounds selected descriptor, local table selectors unchecked
// - null selector loads into data registers, faults into code or stack, references fault
// - less privileged access to privileged faults
// - checks only in protected mode
// - current privilege kept in code, stack selectors
// - requester privilege overrides when less privileged
// - privilege checked at load, data versus transfer
// - privilege 00 highest, 11 lowest
// - descriptor cached in hidden register part
`include "segp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module segp_checker (
  input  wire logic        clk_i,                 // Core clock, 50 MHz
  input  wire logic        rst_i,                 // Synchronous reset, active high
  input  wire logic        ce_i,                  // Clock enable, freezes state when low
  input  wire logic        protected_mode_on_i,   // Protected mode select bit
  input  wire logic        global_table_wr_i,     // Load global table limit
  input  wire logic [15:0] global_table_limit_i,  // New global table limit
  input  wire logic        int_table_wr_i,        // Load interrupt table limit
  input  wire logic [15:0] int_table_limit_i,     // New interrupt table limit
  input  wire logic        load_valid_i,          // Segment register load request
  input  wire logic [2:0]  load_seg_i,            // Target segment register
  input  wire logic [15:0] load_sel_i,            // Selector to load
  input  wire logic [63:0] load_desc_i,           // Descriptor fetched for selector
  input  wire logic        acc_valid_i,           // Memory access request
  input  wire logic [2:0]  acc_seg_i,             // Segment register used
  input  wire logic [31:0] acc_off_i,             // Offset in segment
  input  wire logic [1:0]  acc_width_i,           // Width code
  input  wire logic        acc_write_i,           // High for write
  input  wire logic        intv_valid_i,          // Interrupt vector lookup request
  input  wire logic [7:0]  intv_num_i,            // Vector number
  output logic             load_done_o,           // Load checked
  output logic             acc_done_o,            // Access checked
  output logic             intv_done_o,           // Vector checked
  output logic             gp_fault_o,            // General-protection fault
  output logic [15:0]      fault_sel_o,           // Offending selector, zero for access
  output logic [31:0]      lin_addr_o,            // Linear address of accepted access
  output logic [3:0]       sys_kind_o,            // Decoded system type of last load
  output logic [1:0]       current_priv_o         // Current privilege level
);

  // Whole state of the block
  typedef struct packed {
    segp_pkg::segp_cache_t [`SEGP_NUM_SEG-1:0] seg;
    logic [15:0] gt_limit;
    logic [15:0] it_limit;
    logic        load_done;
    logic        acc_done;
    logic        intv_done;
    logic        gp_fault;
    logic [15:0] fault_sel;
    logic [31:0] lin_addr;
    logic [3:0]  sys_kind;
  } segp_state_t;

  segp_state_t st_q;   // Registered state
  segp_state_t st_d;   // Next state

  // Map a type code onto the system kind, reserved codes to zero
  function automatic logic [3:0] segp_sys_decode(input logic [3:0] t);
    case (t)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: segp_sys_decode = t;
      4'h9, 4'hB, 4'hC, 4'hE, 4'hF:             segp_sys_decode = t;
      default:                                  segp_sys_decode = segp_pkg::SEGP_SYS_RSVD;
    endcase
  endfunction : segp_sys_decode

  // Bytes minus one for a width code
  function automatic logic [31:0] segp_span(input logic [1:0] w);
    case (w)
      segp_pkg::SEGP_W_BYTE:  segp_span = 32'h00000000;
      segp_pkg::SEGP_W_WORD:  segp_span = 32'h00000001;
      default:                segp_span = 32'h00000003;
    endcase
  endfunction : segp_span

  // Descriptor fields of the incoming load
  logic [3:0]  d_typ;
  logic        d_s;
  logic [1:0]  d_dpl;
  logic [31:0] d_base;
  logic [31:0] d_lim;
  logic        d_exec;
  logic [1:0]  current_priv;
  logic [1:0]  requester_priv;
  logic [1:0]  eff_priv;
  logic        sel_null;
  logic        tbl_bad;
  logic        ld_bad;
  segp_pkg::segp_cache_t acc_c;
  logic [32:0] acc_end;
  logic        acc_exec;
  logic        acc_down;
  logic        lim_bad;
  logic        typ_bad;
  logic        acc_bad;
  logic        intv_bad;

  // Field extraction and check terms
  always_comb begin
    d_typ    = load_desc_i[`SEGP_D_TYPE_HI:`SEGP_D_TYPE_LO];
    d_s      = load_desc_i[`SEGP_D_SBIT];
    d_dpl    = load_desc_i[`SEGP_D_DPL_HI:`SEGP_D_DPL_LO];
    d_base   = {load_desc_i[`SEGP_D_BASEHI_HI:`SEGP_D_BASEHI_LO],
                load_desc_i[`SEGP_D_BASELO_HI:`SEGP_D_BASELO_LO]};
    d_exec   = d_s & d_typ[`SEGP_T_EXEC];
    // Effective limit, scaled or raw
    if (load_desc_i[`SEGP_D_G]) begin
      d_lim = {load_desc_i[`SEGP_D_LIMHI_HI:`SEGP_D_LIMHI_LO],
               load_desc_i[`SEGP_D_LIMLO_HI:0], `SEGP_SCALE_FILL};
    end else begin
      d_lim = {12'h000, load_desc_i[`SEGP_D_LIMHI_HI:`SEGP_D_LIMHI_LO],
               load_desc_i[`SEGP_D_LIMLO_HI:0]};
    end
    current_priv      = st_q.seg[`SEGP_SEG_CODE].sel[1:0];
    requester_priv      = load_sel_i[1:0];
    eff_priv = (requester_priv > current_priv) ? requester_priv : current_priv;
    sel_null = (load_sel_i[15:2] == 14'h0000);
    // Descriptor must lie inside global table
    tbl_bad  = !load_sel_i[2] && !sel_null &&
               ({load_sel_i[15:3], 3'h7} > st_q.gt_limit);
    // Type and privilege checks per target register
    case (load_seg_i)
      `SEGP_SEG_CODE: begin
        ld_bad = sel_null | !d_exec |
                 (d_typ[`SEGP_T_CONF_DOWN] ? (d_dpl > current_priv) : (d_dpl != current_priv));
      end
      `SEGP_SEG_STACK: begin
        ld_bad = sel_null | !d_s | d_typ[`SEGP_T_EXEC] | !d_typ[`SEGP_T_RD_WR] |
                 (d_dpl != current_priv) | (requester_priv != current_priv);
      end
      default: begin
        if (sel_null) begin
          ld_bad = 1'b0;
        end else begin
          ld_bad = !d_s | (d_exec & !d_typ[`SEGP_T_RD_WR]) |
                   (!(d_exec & d_typ[`SEGP_T_CONF_DOWN]) & (d_dpl < eff_priv));
        end
      end
    endcase
    ld_bad = protected_mode_on_i & (ld_bad | tbl_bad);
    // Access checks on cached copy
    acc_c    = st_q.seg[acc_seg_i];
    acc_end  = {1'b0, acc_off_i} + {1'b0, segp_span(acc_width_i)};
    acc_exec = acc_c.sbit & acc_c.typ[`SEGP_T_EXEC];
    acc_down = acc_c.sbit & !acc_c.typ[`SEGP_T_EXEC] & acc_c.typ[`SEGP_T_CONF_DOWN];
    if (acc_down) begin
      lim_bad = (acc_off_i <= acc_c.limit) | acc_end[32];
    end else begin
      lim_bad = acc_end > {1'b0, acc_c.limit};
    end
    if (acc_write_i) begin
      typ_bad = acc_exec | !acc_c.typ[`SEGP_T_RD_WR];
    end else begin
      typ_bad = acc_exec & !acc_c.typ[`SEGP_T_RD_WR];
    end
    acc_bad  = protected_mode_on_i & (acc_c.nul | !acc_c.sbit | typ_bad | lim_bad);
    intv_bad = protected_mode_on_i & ({5'h00, intv_num_i, 3'h7} > st_q.it_limit);
  end

  // Next-state logic
  always_comb begin
    st_d           = st_q;
    st_d.load_done = 1'b0;
    st_d.acc_done  = 1'b0;
    st_d.intv_done = 1'b0;
    st_d.gp_fault  = 1'b0;
    st_d.fault_sel = 16'h0000;
    // Table limit registers
    if (global_table_wr_i) begin
      st_d.gt_limit = global_table_limit_i;
    end
    if (int_table_wr_i) begin
      st_d.it_limit = int_table_limit_i;
    end
    // Access uses the cache as it stood before any load this cycle
    if (acc_valid_i) begin
      st_d.acc_done = 1'b1;
      if (acc_bad) begin
        st_d.gp_fault = 1'b1;
      end else begin
        st_d.lin_addr = acc_c.base + acc_off_i;
      end
    end
    // Vector lookup against interrupt table
    if (intv_valid_i) begin
      st_d.intv_done = 1'b1;
      if (intv_bad) begin
        st_d.gp_fault = 1'b1;
      end
    end
    // Segment register load
    if (load_valid_i) begin
      st_d.load_done = 1'b1;
      st_d.sys_kind  = d_s ? segp_pkg::SEGP_SYS_RSVD : segp_sys_decode(d_typ);
      if (ld_bad) begin
        st_d.gp_fault  = 1'b1;
        st_d.fault_sel = load_sel_i;
      end else if (!protected_mode_on_i) begin
        // Real address mode: paragraph base, 64K limit
        st_d.seg[load_seg_i].sel   = load_sel_i;
        st_d.seg[load_seg_i].base  = {12'h000, load_sel_i, 4'h0};
        st_d.seg[load_seg_i].limit = `SEGP_REAL_LIMIT;
        st_d.seg[load_seg_i].typ   = `SEGP_REAL_TYPE;
        st_d.seg[load_seg_i].sbit  = 1'b1;
        st_d.seg[load_seg_i].segment_priv_level   = `SEGP_RST_PRIV;
        st_d.seg[load_seg_i].nul   = 1'b0;
      end else begin
        st_d.seg[load_seg_i].sel   = load_sel_i;
        st_d.seg[load_seg_i].base  = d_base;
        st_d.seg[load_seg_i].limit = d_lim;
        st_d.seg[load_seg_i].typ   = d_typ;
        st_d.seg[load_seg_i].sbit  = d_s;
        st_d.seg[load_seg_i].segment_priv_level   = d_dpl;
        st_d.seg[load_seg_i].nul   = sel_null;
        if (load_seg_i == `SEGP_SEG_CODE) begin
          if (d_typ[`SEGP_T_CONF_DOWN]) begin
            st_d.seg[`SEGP_SEG_CODE].sel[1:0] = current_priv;
          end else begin
            st_d.seg[`SEGP_SEG_CODE].sel[1:0]  = d_dpl;
            st_d.seg[`SEGP_SEG_STACK].sel[1:0] = d_dpl;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      for (int i = 0; i < `SEGP_NUM_SEG; i++) begin
        st_q.seg[i].nul <= 1'b1;
      end
      st_q.gt_limit <= `SEGP_RST_TBL_LIMIT;
      st_q.it_limit <= `SEGP_RST_TBL_LIMIT;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign load_done_o    = st_q.load_done;
  assign acc_done_o     = st_q.acc_done;
  assign intv_done_o    = st_q.intv_done;
  assign gp_fault_o     = st_q.gp_fault;
  assign fault_sel_o    = st_q.fault_sel;
  assign lin_addr_o     = st_q.lin_addr;
  assign sys_kind_o     = st_q.sys_kind;
  assign current_priv_o = st_q.seg[`SEGP_SEG_CODE].sel[1:0];

  // Non-executable descriptor into code register faults
  AST_CS_EXEC: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && load_valid_i && load_seg_i == `SEGP_SEG_CODE && protected_mode_on_i && !d_exec)
    |=> (gp_fault_o && load_done_o && fault_sel_o == $past(load_sel_i)))
    else $error("code load of non-executable not faulted");

  // Execute-only into data register faults
  AST_DATA_XONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && load_valid_i && load_seg_i == `SEGP_SEG_DATA && protected_mode_on_i &&
     !sel_null && d_exec && !d_typ[`SEGP_T_RD_WR]) |=> gp_fault_o)
    else $error("execute-only load into data register not faulted");

  // Read-only data into stack register faults
  AST_SS_WRITABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && load_valid_i && load_seg_i == `SEGP_SEG_STACK && protected_mode_on_i &&
     !d_typ[`SEGP_T_RD_WR]) |=> gp_fault_o)
    else $error("stack load of non-writable not faulted");

  // Writes to executable segment fault
  AST_WR_EXEC: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc_valid_i && acc_write_i && protected_mode_on_i && acc_exec)
    |=> (gp_fault_o && acc_done_o))
    else $error("write to executable segment not faulted");

  // Null selector reference faults
  AST_NULL_REF: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc_valid_i && protected_mode_on_i && acc_c.nul) |=> gp_fault_o)
    else $error("reference through null selector not faulted");

  // Byte beyond limit of expand-up segment faults
  AST_LIMIT_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc_valid_i && protected_mode_on_i && !acc_down &&
     acc_width_i == segp_pkg::SEGP_W_BYTE && acc_off_i > acc_c.limit) |=> gp_fault_o)
    else $error("byte past limit not faulted");

  // Descriptor past global table limit faults
  AST_TABLE_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && load_valid_i && protected_mode_on_i && !load_sel_i[2] && !sel_null &&
     {load_sel_i[15:3], 3'h7} > st_q.gt_limit) |=> gp_fault_o)
    else $error("selector beyond table limit not faulted");

  // Real address mode never faults
  AST_REAL_NOCHK: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !protected_mode_on_i) |=> !gp_fault_o)
    else $error("fault raised in real address mode");

  // Accepted non-conforming code load sets current privilege
  AST_CPL_UPDATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && load_valid_i && load_seg_i == `SEGP_SEG_CODE && protected_mode_on_i &&
     !ld_bad && !d_typ[`SEGP_T_CONF_DOWN])
    |=> (current_priv_o == $past(d_dpl) && st_q.seg[`SEGP_SEG_STACK].sel[1:0] == $past(d_dpl)))
    else $error("current privilege not updated");

endmodule : segp_checker
`default_nettype wire

// file: sim/segp_pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
// Pipeline stand-in: issues table writes, segment loads, accesses and vector lookups
module segp_pipe_model (
  input  wire logic clk_i,        // Core clock
  output logic      pm_o,         // Protected mode select
  output logic      gt_wr_o,      // Global table limit write
  output logic [15:0] gt_lim_o,   // Global table limit
  output logic      it_wr_o,      // Interrupt table limit write
  output logic [15:0] it_lim_o,   // Interrupt table limit
  output logic      ld_v_o,       // Load request
  output logic [2:0]  ld_seg_o,   // Load target
  output logic [15:0] ld_sel_o,   // Load selector
  output logic [63:0] ld_desc_o,  // Load descriptor
  output logic      ac_v_o,       // Access request
  output logic [2:0]  ac_seg_o,   // Access segment
  output logic [31:0] ac_off_o,   // Access offset
  output logic [1:0]  ac_w_o,     // Access width
  output logic      ac_wr_o,      // Access direction
  output logic      iv_v_o,       // Vector request
  output logic [7:0]  iv_num_o    // Vector number
);
  // Idle values at time zero
  initial begin
    {pm_o, gt_wr_o, it_wr_o, ld_v_o, ac_v_o, iv_v_o} = 6'h20;
    {gt_lim_o, it_lim_o, ld_seg_o, ld_sel_o, ld_desc_o} = '0;
    {ac_seg_o, ac_off_o, ac_w_o, ac_wr_o, iv_num_o} = '0;
  end
  // Mode changes off the sampling edge
  task automatic mode(input logic m);
    @(posedge clk_i); #1 pm_o = m;
  endtask : mode
  // Both table limits written in one cycle
  task automatic tbl(input logic [15:0] g, input logic [15:0] i);
    @(posedge clk_i); #1 {gt_wr_o, gt_lim_o, it_wr_o, it_lim_o} = {1'b1, g, 1'b1, i};
    @(posedge clk_i); #1 {gt_wr_o, gt_lim_o, it_wr_o, it_lim_o} = {1'b0, ~g, 1'b0, ~i};
  endtask : tbl
  // Load held for one taking edge; released fields show inverted junk
  task automatic load(input logic [2:0] s, input logic [15:0] sel, input logic [63:0] d);
    @(posedge clk_i); #1 {ld_v_o, ld_seg_o, ld_sel_o, ld_desc_o} = {1'b1, s, sel, d};
    @(posedge clk_i); #1 {ld_v_o, ld_sel_o, ld_desc_o} = {1'b0, ~sel, ~d};
  endtask : load
  // Every access carries segment, offset, width and direction
  task automatic acc(input logic [2:0] s, input logic [31:0] o, input logic [1:0] w, input logic wr);
    @(posedge clk_i); #1 {ac_v_o, ac_seg_o, ac_off_o, ac_w_o, ac_wr_o} = {1'b1, s, o, w, wr};
    @(posedge clk_i); #1 {ac_v_o, ac_off_o, ac_wr_o} = {1'b0, ~o, ~wr};
  endtask : acc
  // Vector lookup
  task automatic vec(input logic [7:0] n);
    @(posedge clk_i); #1 {iv_v_o, iv_num_o} = {1'b1, n};
    @(posedge clk_i); #1 {iv_v_o, iv_num_o} = {1'b0, ~n};
  endtask : vec
endmodule : segp_pipe_model
`default_nettype wire

// file: sim/segp_checker_tb.sv
`include "segp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module segp_checker_tb;
  logic clk_i = 1'b0;   // Core clock
  logic rst_i = 1'b1;   // Reset
  logic ce = 1'b1;      // Clock enable
  int   err_total = 0;  // Mismatches
  int   checks_done = 0; // Comparisons
  logic pm, gwr, iwr, lv, av, iv, awr, ldn, adn, idn, gpf;
  logic [15:0] glim, ilim, lsel, fsel;
  logic [2:0]  lseg, aseg;
  logic [63:0] ldesc;
  logic [31:0] aoff, lin;
  logic [1:0]  aw, current_priv;
  logic [7:0]  inum;
  logic [3:0]  kind;
  localparam logic [2:0] SC = `SEGP_SEG_CODE, SS = `SEGP_SEG_STACK, SD = `SEGP_SEG_DATA;
  localparam logic [2:0] SE = `SEGP_SEG_EXTRA, SF = `SEGP_SEG_AUXF, SG = `SEGP_SEG_AUXG;
  localparam logic [1:0] WB = segp_pkg::SEGP_W_BYTE, WW = segp_pkg::SEGP_W_WORD, WD = segp_pkg::SEGP_W_DWORD;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  segp_checker segp_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .protected_mode_on_i(pm),
    .global_table_wr_i(gwr), .global_table_limit_i(glim), .int_table_wr_i(iwr), .int_table_limit_i(ilim),
    .load_valid_i(lv), .load_seg_i(lseg), .load_sel_i(lsel), .load_desc_i(ldesc), .acc_valid_i(av),
    .acc_seg_i(aseg), .acc_off_i(aoff), .acc_width_i(aw), .acc_write_i(awr), .intv_valid_i(iv),
    .intv_num_i(inum), .load_done_o(ldn), .acc_done_o(adn), .intv_done_o(idn), .gp_fault_o(gpf),
    .fault_sel_o(fsel), .lin_addr_o(lin), .sys_kind_o(kind), .current_priv_o(current_priv));
  segp_pipe_model segp_pipe_model_inst (.clk_i(clk_i), .pm_o(pm), .gt_wr_o(gwr), .gt_lim_o(glim),
    .it_wr_o(iwr), .it_lim_o(ilim), .ld_v_o(lv), .ld_seg_o(lseg), .ld_sel_o(lsel), .ld_desc_o(ldesc),
    .ac_v_o(av), .ac_seg_o(aseg), .ac_off_o(aoff), .ac_w_o(aw), .ac_wr_o(awr), .iv_v_o(iv), .iv_num_o(inum));
  // Descriptor builder: present and 32-bit default set
  function automatic logic [63:0] dsc(input logic [31:0] b, input logic [19:0] l, input logic [3:0] t,
                                      input logic s, input logic [1:0] p, input logic g);
    dsc = {b[31:24], g, 1'b1, 2'h0, l[19:16], 1'b1, p, s, t, b[23:0], l[15:0]};
  endfunction : dsc
  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // Load and judge the answer one cycle later
  task automatic ld(input logic [2:0] s, input logic [15:0] sel, input logic [63:0] d, input logic f);
    segp_pipe_model_inst.load(s, sel, d);
    chk(ldn, 1, "load done");
    chk(gpf, f, "load fault");
    chk(fsel, f ? sel : 16'h0000, "fault selector");
  endtask : ld
  // Access and judge fault or linear address
  task automatic ac(input logic [2:0] s, input logic [31:0] o, input logic [1:0] w, input logic wr,
                    input logic f, input logic [31:0] la);
    segp_pipe_model_inst.acc(s, o, w, wr);
    chk(adn, 1, "access done");
    chk(gpf, f, "access fault");
    if (!f) chk(lin, la, "linear address");
  endtask : ac
  // Reset state and descriptor type decode
  task automatic t_types;
    chk(current_priv, 0, "reset privilege");
    ac(SD, 32'h0, WB, 1'b0, 1'b1, 0);
    segp_pipe_model_inst.tbl(16'hFFFF, 16'hFFFF);
    for (int c = 0; c < 16; c++) begin
      ld(SD, 16'h0008, dsc(0, 20'hFFFFF, c[3:0], 1'b0, 2'h0, 1'b0), 1'b1);
      chk(kind, (c == 0 || c == 8 || c == 10 || c == 13) ? 0 : c, "system kind");
    end
    $display("types test done");
  endtask : t_types
  // Register-specific type rules at load and at use
  task automatic t_typeuse;
    ld(SC, 16'h0008, dsc(0, 20'hFFFFF, 4'h2, 1'b1, 2'h0, 1'b0), 1'b1);
    ld(SC, 16'h0008, dsc(0, 20'hFFFFF, 4'hA, 1'b1, 2'h0, 1'b0), 1'b0);
    chk(current_priv, 0, "privilege after code load");
    ld(SD, 16'h0008, dsc(0, 20'hFFFFF, 4'h8, 1'b1, 2'h0, 1'b0), 1'b1);
    ld(SS, 16'h0008, dsc(0, 20'hFFFFF, 4'h0, 1'b1, 2'h0, 1'b0), 1'b1);
    ld(SS, 16'h0008, dsc(0, 20'hFFFFF, 4'hA, 1'b1, 2'h0, 1'b0), 1'b1);
    ld(SS, 16'h0008, dsc(0, 20'hFFFFF, 4'h2, 1'b1, 2'h0, 1'b0), 1'b0);
    ld(SD, 16'h0008, dsc(32'h2000, 20'hFFFFF, 4'hA, 1'b1, 2'h0, 1'b0), 1'b0);
    ac(SD, 32'h4, WD, 1'b1, 1'b1, 0);
    ac(SD, 32'h4, WD, 1'b0, 1'b0, 32'h2004);
    ac(SC, 32'h8, WB, 1'b0, 1'b0, 32'h8);
    ac(SC, 32'h8, WB, 1'b1, 1'b1, 0);
    ld(SE, 16'h0008, dsc(0, 20'hFFFFF, 4'h0, 1'b1, 2'h0, 1'b0), 1'b0);
    ac(SE, 32'h0, WB, 1'b1, 1'b1, 0);
    ld(SC, 16'h0008, dsc(0, 20'hFFFFF, 4'h8, 1'b1, 2'h0, 1'b0), 1'b0);
    ac(SC, 32'h8, WB, 1'b0, 1'b1, 0);
    ld(SG, 16'h0008, dsc(0, 20'hFFFFF, 4'h8, 1'b1, 2'h0, 1'b0), 1'b1);
    $display("type use test done");
  endtask : t_typeuse
  // Limit boundaries for each width, scaled and raw
  task automatic t_limits;
    ld(SD, 16'h0008, dsc(32'h1000, 20'h00010, 4'h2, 1'b1, 2'h0, 1'b0), 1'b0);
    ac(SD, 32'h10, WB, 1'b1, 1'b0, 32'h1010);
    ac(SD, 32'h11, WB, 1'b0, 1'b1, 0);
    ac(SD, 32'h0F, WW, 1'b0, 1'b0, 32'h100F);
    ac(SD, 32'h10, WW, 1'b0, 1'b1, 0);
    ac(SD, 32'h0D, WD, 1'b0, 1'b0, 32'h100D);
    ac(SD, 32'h0E, WD, 1'b0, 1'b1, 0);
    ac(SD, 32'h0D, 2'h3, 1'b0, 1'b0, 32'h100D);
    ac(SD, 32'h0E, 2'h3, 1'b0, 1'b1, 0);
    ld(SF, 16'h0008, dsc(0, 20'hFFFFF, 4'h2, 1'b1, 2'h0, 1'b0), 1'b0);
    ac(SF, 32'hFFFFF, WB, 1'b0, 1'b0, 32'hFFFFF);
    ac(SF, 32'h100000, WB, 1'b0, 1'b1, 0);
    ld(SF, 16'h0008, dsc(0, 20'h00000, 4'h2, 1'b1, 2'h0, 1'b1), 1'b0);
    ac(SF, 32'hFFF, WB, 1'b0, 1'b0, 32'hFFF);
    ac(SF, 32'h1000, WB, 1'b0, 1'b1, 0);
    ld(SE, 16'h0008, dsc(0, 20'h00010, 4'h6, 1'b1, 2'h0, 1'b0), 1'b0);
    ac(SE, 32'h10, WB, 1'b0, 1'b1, 0);
    ac(SE, 32'h11, WB, 1'b1, 1'b0, 32'h11);
    ac(SE, 32'hFFFFFFFC, WD, 1'b0, 1'b0, 32'hFFFFFFFC);
    ac(SE, 32'hFFFFFFFD, WD, 1'b0, 1'b1, 0);
    $display("limits test done");
  endtask : t_limits
  // Table limits, null selector and privilege levels
  task automatic t_tables_priv;
    segp_pipe_model_inst.tbl(16'h0017, 16'h000F);
    ld(SD, 16'h0010, dsc(0, 20'hFFFFF, 4'h2, 1'b1, 2'h0, 1'b0), 1'b0);
    ld(SD, 16'h0018, dsc(0, 20'hFFFFF, 4'h2, 1'b1, 2'h0, 1'b0), 1'b1);
    segp_pipe_model_inst.vec(8'h01);
    chk(idn, 1, "vector done");
    chk(gpf, 0, "vector in range");
    segp_pipe_model_inst.vec(8'h02);
    chk(gpf, 1, "vector past limit");
    segp_pipe_model_inst.tbl(16'hFFFF, 16'hFFFF);
    ld(SD, 16'h0000, 64'h0, 1'b0);
    ac(SD, 32'h0, WB, 1'b0, 1'b1, 0);
    ld(SD, 16'h000A, dsc(0, 20'hFFFFF, 4'h2, 1'b1, 2'h1, 1'b0), 1'b1);
    ld(SD, 16'h000A, dsc(0, 20'hFFFFF, 4'h2, 1'b1, 2'h2, 1'b0), 1'b0);
    ld(SC, 16'h0008, dsc(0, 20'hFFFFF, 4'hA, 1'b1, 2'h3, 1'b0), 1'b1);
    ld(SC, 16'h000B, dsc(0, 20'hFFFFF, 4'hE, 1'b1, 2'h0, 1'b0), 1'b0);
    chk(current_priv, 0, "conforming keeps privilege");
    $display("tables and privilege test done");
  endtask : t_tables_priv
  // Real address mode skips all checks
  task automatic t_real;
    segp_pipe_model_inst.mode(1'b0);
    ld(SD, 16'h1234, 64'h0, 1'b0);
    ac(SD, 32'h10, WB, 1'b1, 1'b0, 32'h12350);
    $display("real mode test done");
  endtask : t_real
  // Clock enable low freezes state and ignores requests
  task automatic t_freeze;
    @(posedge clk_i); #1 ce = 1'b0;
    segp_pipe_model_inst.load(SE, 16'h1000, 64'h0);
    chk(ldn, 0, "frozen load ignored");
    segp_pipe_model_inst.acc(SE, 32'h10, WB, 1'b0);
    chk(adn, 0, "frozen access ignored");
    @(posedge clk_i); #1 ce = 1'b1;
    ac(SE, 32'h20, WB, 1'b0, 1'b0, 32'h20);
    $display("freeze test done");
  endtask : t_freeze
  // Count report, verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Main sequence: 20-cycle reset, then each scenario
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_types();
    t_typeuse();
    t_limits();
    t_tables_priv();
    t_real();
    t_freeze();
    tally_and_finish();
  end
endmodule : segp_checker_tb
`default_nettype wire
